// ==== common/adc_seq_pkg.sv ====
package adc_seq_pkg;
  localparam logic [7:0] ADDR_SEQ_START = 8'h00;
  localparam logic [7:0] ADDR_SEQ_CFG = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_RESULT = 8'h0c;
  localparam int START_W = 8;
  localparam int CFG_W = 10;
  localparam logic [7:0] SEQ_START_RESET = 8'h00;
  localparam logic [9:0] SEQ_CFG_RESET = 10'h04f;
  localparam int BIT_JUSTIFY = 7;
  localparam int BIT_SIGNED = 6;
  localparam int BIT_SCAN = 5;
  localparam int BIT_MULTI = 4;
  localparam int CHAN_LSB = 0;
  localparam int CHAN_W = 4;
  localparam logic [3:0] CHAN_MAX = 4'hf;
  localparam logic [3:0] CHAN_FIRST = 4'h0;
  localparam int WRAP_LSB = 0;
  localparam int BIT_ETRIG = 4;
  localparam int BIT_LOWRES = 5;
  localparam int LEN_LSB = 6;
  localparam int LEN_W = 4;
  localparam int ST_BUSY = 0;
  localparam int ST_ARMED = 1;
  localparam int ST_DONE = 2;
  localparam int ST_CHAN_LSB = 4;
  localparam int ST_CNT_LSB = 8;
  localparam int RAW_W = 10;
  localparam int RES_W = 16;
  localparam int PAD_L8 = 8;
  localparam int PAD_L10 = 6;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_WAIT = 3'b100
  } seq_state_t;
endpackage

// ==== common/result_fmt_if.sv ====
`timescale 1ns/1ps
interface result_fmt_if;
  logic [9:0] raw;
  logic low_res;
  logic right;
  logic sgn;
  logic [15:0] word;
  modport fmt (input raw, input low_res, input right, input sgn, output word);
  modport user (output raw, output low_res, output right, output sgn, input word);
endinterface

// ==== logic/result_formatter.sv ====
`timescale 1ns/1ps
module result_formatter
  import adc_seq_pkg::*;
(
  result_fmt_if.fmt f
);
  logic [7:0] code8;
  logic top_bit;
  always_comb begin
    code8 = f.raw[RAW_W-1:RAW_W-8];
    // Signed only applies when left justified
    top_bit = f.raw[RAW_W-1] ^ (f.sgn & ~f.right);
    if (f.right) begin
      if (f.low_res) begin
        f.word = {{(RES_W-8){1'b0}}, code8};
      end else begin
        f.word = {{(RES_W-RAW_W){1'b0}}, f.raw};
      end
    end else if (f.low_res) begin
      f.word = {top_bit, code8[6:0], {PAD_L8{1'b0}}};
    end else begin
      f.word = {top_bit, f.raw[RAW_W-2:0], {PAD_L10{1'b0}}};
    end
  end
endmodule

// ==== logic/adc_sequence_start_control.sv ====
`timescale 1ns/1ps
module adc_sequence_start_control
  import adc_seq_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Converter side
  input wire logic i_ext_trigger,
  input wire logic i_conv_done,
  input wire logic [9:0] i_conv_data,
  output logic o_sample_start,
  output logic [3:0] o_sample_channel,
  // Formatted results
  output logic [15:0] o_result,
  output logic o_result_valid
);

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == ADDR_SEQ_START) || (a == ADDR_SEQ_CFG) ||
                  (a == ADDR_STATUS) || (a == ADDR_RESULT);
  endfunction

  function automatic logic [3:0] step_chan(
    input logic [3:0] c,
    input logic [3:0] w,
    input logic pend
  );
    if (c == CHAN_MAX || (!pend && c == w)) begin
      step_chan = CHAN_FIRST;
    end else begin
      step_chan = c + 4'h1;
    end
  endfunction

  // Register state
  logic [7:0] seq_start;
  logic [7:0] next_seq_start;
  logic [9:0] seq_cfg;
  logic [9:0] next_seq_cfg;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;

  // Sequencer state
  seq_state_t state;
  seq_state_t next_state;
  logic [3:0] next_sample_channel;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic armed;
  logic next_armed;
  logic wrap_pend;
  logic next_wrap_pend;
  logic done;
  logic next_done;
  logic next_sample_start;
  logic [15:0] next_result;
  logic next_result_valid;
  logic [9:0] res_raw;
  logic [9:0] next_res_raw;

  // Decoded controls
  logic wr_access;
  logic wr_start;
  logic wr_cfg;
  logic setup;
  logic justify_right_sel;
  logic signed_result_sel;
  logic scan_sel;
  logic multi_channel_sel;
  logic [3:0] chan_code;
  logic [3:0] wrap_chan;
  logic ext_trigger_enable;
  logic low_resolution_sel;
  logic [3:0] seq_len;
  logic last_conv;
  logic trig_start;

  result_fmt_if fmt_bus ();

  result_formatter result_formatter_inst (
    .f(fmt_bus)
  );

  assign justify_right_sel = seq_start[BIT_JUSTIFY];
  assign signed_result_sel = seq_start[BIT_SIGNED];
  assign scan_sel = seq_start[BIT_SCAN];
  assign multi_channel_sel = seq_start[BIT_MULTI];
  assign chan_code = seq_start[CHAN_LSB +: CHAN_W];
  assign wrap_chan = seq_cfg[WRAP_LSB +: CHAN_W];
  assign ext_trigger_enable = seq_cfg[BIT_ETRIG];
  assign low_resolution_sel = seq_cfg[BIT_LOWRES];
  assign seq_len = seq_cfg[LEN_LSB +: LEN_W];

  assign fmt_bus.raw = i_conv_data;
  assign fmt_bus.low_res = low_resolution_sel;
  assign fmt_bus.right = justify_right_sel;
  assign fmt_bus.sgn = signed_result_sel;
  logic [3:0] cur_chan;
  assign o_sample_channel = cur_chan;

  // Bus decode
  always_comb begin
    setup = i_psel && !i_penable;
    wr_access = i_psel && i_penable && o_pready && i_pwrite;
    wr_start = wr_access && (i_paddr == ADDR_SEQ_START);
    wr_cfg = wr_access && (i_paddr == ADDR_SEQ_CFG);
  end

  // Register file and read path
  always_comb begin
    next_seq_start = seq_start;
    next_seq_cfg = seq_cfg;
    next_pready = setup;
    next_pslverr = setup && !addr_mapped(i_paddr);
    next_prdata = 32'h0000_0000;
    if (wr_start) begin
      next_seq_start = i_pwdata[START_W-1:0];
    end
    if (wr_cfg) begin
      next_seq_cfg = i_pwdata[CFG_W-1:0];
    end
    if (setup && !i_pwrite) begin
      unique case (i_paddr)
        ADDR_SEQ_START: next_prdata[START_W-1:0] = seq_start;
        ADDR_SEQ_CFG: next_prdata[CFG_W-1:0] = seq_cfg;
        ADDR_STATUS: begin
          next_prdata[ST_BUSY] = (state != ST_IDLE);
          next_prdata[ST_ARMED] = armed;
          next_prdata[ST_DONE] = done;
          next_prdata[ST_CHAN_LSB +: CHAN_W] = cur_chan;
          next_prdata[ST_CNT_LSB +: LEN_W] = cnt;
        end
        ADDR_RESULT: next_prdata[RES_W-1:0] = o_result;
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      seq_start <= SEQ_START_RESET;
      seq_cfg <= SEQ_CFG_RESET;
      o_prdata <= 32'h0000_0000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      seq_start <= next_seq_start;
      seq_cfg <= next_seq_cfg;
      o_prdata <= next_prdata;
      o_pready <= next_pready;
      o_pslverr <= next_pslverr;
    end
  end

  // Sequencer
  assign last_conv = (cnt == seq_len - 4'h1);
  assign trig_start = ext_trigger_enable && armed && i_ext_trigger && (state == ST_IDLE);

  always_comb begin
    next_state = state;
    next_sample_channel = cur_chan;
    next_cnt = cnt;
    next_armed = armed;
    next_wrap_pend = wrap_pend;
    next_done = done;
    next_res_raw = res_raw;
    next_result = o_result;
    next_result_valid = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (trig_start) begin
          next_state = ST_SAMPLE;
          next_sample_channel = chan_code;
          next_cnt = 4'h0;
          next_wrap_pend = multi_channel_sel && (chan_code > wrap_chan);
        end
      end
      ST_SAMPLE: begin
        next_state = ST_WAIT;
      end
      ST_WAIT: begin
        if (i_conv_done) begin
          next_res_raw = i_conv_data;
          next_result = fmt_bus.word;
          next_result_valid = 1'b1;
          if (last_conv) begin
            next_done = 1'b1;
            if (scan_sel && !ext_trigger_enable) begin
              next_state = ST_SAMPLE;
              next_sample_channel = chan_code;
              next_cnt = 4'h0;
              next_wrap_pend = multi_channel_sel && (chan_code > wrap_chan);
            end else begin
              next_state = ST_IDLE;
            end
          end else begin
            next_state = ST_SAMPLE;
            next_cnt = cnt + 4'h1;
            if (multi_channel_sel) begin
              next_sample_channel = step_chan(cur_chan, wrap_chan, wrap_pend);
              if (cur_chan == CHAN_MAX) begin
                next_wrap_pend = 1'b0;
              end
            end
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // A sequence-start write wins over any running step; done clear loses to a set
    if (wr_start) begin
      next_cnt = 4'h0;
      next_armed = 1'b1;
      next_wrap_pend = i_pwdata[BIT_MULTI] && (i_pwdata[CHAN_LSB +: CHAN_W] > wrap_chan);
      next_sample_channel = i_pwdata[CHAN_LSB +: CHAN_W];
      next_state = ext_trigger_enable ? ST_IDLE : ST_SAMPLE;
      if (!(state == ST_WAIT && i_conv_done && last_conv)) begin
        next_done = 1'b0;
      end
    end
    next_sample_start = (next_state == ST_SAMPLE);
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state <= ST_IDLE;
      cur_chan <= CHAN_FIRST;
      cnt <= 4'h0;
      armed <= 1'b0;
      wrap_pend <= 1'b0;
      done <= 1'b0;
      res_raw <= 10'h000;
      o_result <= 16'h0000;
      o_result_valid <= 1'b0;
      o_sample_start <= 1'b0;
    end else begin
      state <= next_state;
      cur_chan <= next_sample_channel;
      cnt <= next_cnt;
      armed <= next_armed;
      wrap_pend <= next_wrap_pend;
      done <= next_done;
      res_raw <= next_res_raw;
      o_result <= next_result;
      o_result_valid <= next_result_valid;
      o_sample_start <= next_sample_start;
    end
  end

  // Checks
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_last_conv;
    state == ST_WAIT && i_conv_done && last_conv && !wr_start;
  endsequence

  sequence s_mid_conv;
    state == ST_WAIT && i_conv_done && !last_conv && !wr_start;
  endsequence

  chk_write_restarts: assert property (
    wr_start && !ext_trigger_enable |=> o_sample_start && cur_chan == $past(i_pwdata[CHAN_LSB +: CHAN_W])
      ##1 state == ST_WAIT
  ) else $error("Sequence-start write did not restart sampling");

  chk_trigger_needs_arm: assert property (
    state == ST_IDLE && !armed && !wr_start |=> state == ST_IDLE && !o_sample_start
  ) else $error("Sequence started before the arming write");

  chk_trigger_one_seq: assert property (
    ext_trigger_enable && !wr_cfg ##0 s_last_conv |=> state == ST_IDLE
  ) else $error("Triggered mode ran more than one sequence");

  chk_scan_repeats: assert property (
    scan_sel && !ext_trigger_enable ##0 s_last_conv |=> o_sample_start && cur_chan == chan_code && cnt == 4'h0
  ) else $error("Scan mode did not start the next sequence");

  chk_single_stops: assert property (
    !scan_sel && !wr_cfg ##0 s_last_conv |=> state == ST_IDLE [*2]
  ) else $error("Single sequence did not stop");

  chk_single_channel: assert property (
    !multi_channel_sel && !wr_start ##0 s_mid_conv |=> cur_chan == $past(cur_chan) && o_sample_start
  ) else $error("Single-channel mode moved off its channel");

  chk_multi_step: assert property (
    multi_channel_sel && !wrap_pend && cur_chan != wrap_chan && cur_chan != CHAN_MAX ##0 s_mid_conv
    |=> cur_chan == $past(cur_chan) + 4'h1
  ) else $error("Multi-channel mode did not step by one");

  chk_wrap_to_zero: assert property (
    multi_channel_sel && (cur_chan == CHAN_MAX || (!wrap_pend && cur_chan == wrap_chan)) ##0 s_mid_conv
    |=> cur_chan == CHAN_FIRST
  ) else $error("Channel did not wrap to input 0");

  chk_first_wrap_late: assert property (
    multi_channel_sel && wrap_pend && cur_chan == wrap_chan ##0 s_mid_conv |=> cur_chan == wrap_chan + 4'h1
  ) else $error("First wrap taken before input 15");

  chk_signed_flip: assert property (
    o_result_valid && !justify_right_sel && signed_result_sel |-> o_result[15] == !res_raw[9]
  ) else $error("Signed code top bit not inverted");

  chk_right_clean: assert property (
    o_result_valid && justify_right_sel
    |-> o_result[15:10] == 6'h00 && o_result[9:8] == (low_resolution_sel ? 2'b00 : res_raw[9:8])
  ) else $error("Right-justified result has stray or signed bits");

  chk_left_8bit: assert property (
    o_result_valid && !justify_right_sel && low_resolution_sel |-> o_result[7:0] == 8'h00
      && o_result[14:8] == res_raw[8:2]
  ) else $error("Left-justified 8-bit result misplaced");

  chk_left_10bit: assert property (
    o_result_valid && !justify_right_sel && !low_resolution_sel |-> o_result[5:0] == 6'h00
      && o_result[14:6] == res_raw[8:0]
  ) else $error("Left-justified 10-bit result misplaced");

  chk_apb_answer: assert property (
    i_psel && !i_penable |=> o_pready ##1 !o_pready || (i_psel && !i_penable)
  ) else $error("APB access not answered in one cycle");

  chk_abort_clears_count: assert property (
    wr_start |=> cnt == 4'h0
  ) else $error("Sequence-start write did not clear the count");

endmodule

// ==== sim/adc_sequence_start_control_test.sv ====
`timescale 1ns/1ps
module adc_sequence_start_control_test;
  import adc_seq_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0000_0000;
  logic i_ext_trigger = 1'b0;
  logic i_conv_done = 1'b0;
  logic [9:0] i_conv_data = 10'h000;
  logic [31:0] o_prdata;
  logic o_pready;
  logic o_pslverr;
  logic o_sample_start;
  logic [3:0] o_sample_channel;
  logic [15:0] o_result;
  logic o_result_valid;
  logic [31:0] rdata;
  logic rerr;
  int errors = 0;
  int num_checks = 0;

  always #5 i_core_clk = ~i_core_clk;

  adc_sequence_start_control adc_sequence_start_control_inst (
    .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_ext_trigger(i_ext_trigger), .i_conv_done(i_conv_done), .i_conv_data(i_conv_data),
    .o_sample_start(o_sample_start), .o_sample_channel(o_sample_channel),
    .o_result(o_result), .o_result_valid(o_result_valid)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; ends at the falling edge after completion
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    int n;
    n = 0;
    @(posedge i_core_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= addr;
    i_pwdata <= data;
    @(posedge i_core_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    if (n >= 20) chk(o_pready, 1'b1, "pready wait");
    rdata = o_prdata;
    rerr = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(negedge i_core_clk);
  endtask

  task automatic wait_start(input logic [3:0] ch);
    int n;
    n = 0;
    while (o_sample_start !== 1'b1 && n < 40) begin
      @(negedge i_core_clk);
      n++;
    end
    chk(o_sample_start, 1'b1, "sample start");
    chk(o_sample_channel, ch, "sample channel");
  endtask

  task automatic conv(input logic [9:0] raw, input logic [15:0] exp);
    @(posedge i_core_clk);
    i_conv_done <= 1'b1;
    i_conv_data <= raw;
    @(posedge i_core_clk);
    i_conv_done <= 1'b0;
    @(negedge i_core_clk);
    chk(o_result_valid, 1'b1, "result valid");
    chk(o_result, exp, "result word");
  endtask

  task automatic idle(input int n);
    repeat (n) begin
      chk(o_sample_start, 1'b0, "unexpected start");
      @(negedge i_core_clk);
    end
  endtask

  task automatic trig;
    @(posedge i_core_clk);
    i_ext_trigger <= 1'b1;
    @(posedge i_core_clk);
    i_ext_trigger <= 1'b0;
    @(negedge i_core_clk);
  endtask

  function automatic logic [15:0] fmt(input logic [9:0] raw, input logic lr, input logic rt, input logic sg);
    logic [7:0] v8;
    v8 = raw[9:2];
    if (lr) return rt ? {8'h00, v8} : {v8 ^ {sg, 7'h00}, 8'h00};
    return rt ? {6'h00, raw} : {raw ^ {sg, 9'h000}, 6'h00};
  endfunction

  task automatic t_regs;
    apb(1'b0, ADDR_SEQ_START, 32'h0);
    chk(rdata, {24'h0, SEQ_START_RESET}, "start reg reset");
    apb(1'b0, ADDR_SEQ_CFG, 32'h0);
    chk(rdata, {22'h0, SEQ_CFG_RESET}, "config reg reset");
    apb(1'b1, ADDR_SEQ_START, 32'h0000_0095);
    chk(rerr, 1'b0, "write error flag");
    wait_start(4'h5);
    apb(1'b0, ADDR_SEQ_START, 32'h0);
    chk(rdata, 32'h0000_0095, "start reg readback busy");
    conv(10'h155, fmt(10'h155, 1'b0, 1'b1, 1'b0));
    apb(1'b0, ADDR_RESULT, 32'h0);
    chk(rdata, 32'h0000_0155, "result reg readback");
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rdata, 32'h0000_0056, "status after single sequence");
    apb(1'b0, 8'h40, 32'h0);
    chk(rerr, 1'b1, "unmapped read error");
    chk(rdata, 32'h0, "unmapped read data");
    $display("register test done");
  endtask

  task automatic t_trigger;
    // Reset clears the arming left by earlier writes
    @(posedge i_core_clk);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    @(negedge i_core_clk);
    chk(o_result, 16'h0000, "result after reset");
    chk(o_sample_start, 1'b0, "start after reset");
    apb(1'b1, ADDR_SEQ_CFG, 32'h0000_005f);
    trig();
    idle(6);
    apb(1'b1, ADDR_SEQ_START, 32'h0000_0023);
    idle(6);
    repeat (2) begin
      trig();
      wait_start(4'h3);
      conv(10'h200, 16'h8000);
      idle(10);
    end
    apb(1'b1, ADDR_SEQ_CFG, 32'h0000_004f);
    $display("trigger test done");
  endtask

  task automatic t_format;
    logic [9:0] raws [3] = '{10'h200, 10'h3ff, 10'h001};
    logic [3:0] ch;
    for (int lr = 0; lr < 2; lr++) begin
      apb(1'b1, ADDR_SEQ_CFG, {22'h0, 4'h1, lr[0], 1'b0, 4'hf});
      for (int m = 0; m < 4; m++) begin
        for (int k = 0; k < 3; k++) begin
          ch = 4'(k * 5);
          apb(1'b1, ADDR_SEQ_START, {24'h0, m[1], m[0], 2'b00, ch});
          wait_start(ch);
          conv(raws[k], fmt(raws[k], lr[0], m[1], m[0]));
        end
      end
    end
    apb(1'b1, ADDR_SEQ_CFG, 32'h0000_004f);
    $display("format test done");
  endtask

  task automatic t_scan;
    apb(1'b1, ADDR_SEQ_START, 32'h0000_0025);
    repeat (3) begin
      wait_start(4'h5);
      conv(10'h3ff, 16'hffc0);
    end
    apb(1'b1, ADDR_SEQ_START, 32'h0000_0000);
    wait_start(4'h0);
    conv(10'h3ff, 16'hffc0);
    idle(10);
    $display("scan test done");
  endtask

  task automatic t_abort;
    apb(1'b1, ADDR_SEQ_CFG, 32'h0000_010f);
    apb(1'b1, ADDR_SEQ_START, 32'h0000_0012);
    wait_start(4'h2);
    conv(10'h0ff, 16'h3fc0);
    wait_start(4'h3);
    apb(1'b1, ADDR_SEQ_START, 32'h0000_0009);
    repeat (4) begin
      wait_start(4'h9);
      conv(10'h040, 16'h1000);
    end
    idle(8);
    $display("abort test done");
  endtask

  task automatic run_multi(input logic [3:0] start, input logic [3:0] wrap, input logic [3:0] len);
    logic [3:0] c;
    logic above;
    c = start;
    above = start > wrap;
    apb(1'b1, ADDR_SEQ_CFG, {22'h0, len, 2'b00, wrap});
    apb(1'b1, ADDR_SEQ_START, {24'h0, 4'h1, start});
    repeat ((len == 4'h0) ? 16 : int'(len)) begin
      wait_start(c);
      conv({6'h00, c}, {6'h00, c, 6'h00});
      if (c == (above ? 4'hf : wrap)) begin
        c = 4'h0;
        above = 1'b0;
      end else begin
        c = c + 4'h1;
      end
    end
    idle(8);
    $display("multi-channel run done");
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #500000;
    errors++;
    $display("FAIL at %0t: watchdog expired", $time);
    conclude();
  end

  initial begin
    repeat (8) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    t_regs();
    t_trigger();
    t_format();
    t_scan();
    t_abort();
    run_multi(4'hc, 4'h5, 4'hb);
    run_multi(4'h4, 4'h5, 4'h6);
    run_multi(4'h0, 4'hf, 4'h0);
    conclude();
  end
endmodule
